// [pkg/cec_pkg.sv]
// Constants, types and config layout for capacitive event control.
// Assumes a 40 MHz clock and an analog front end that supplies counts.
// Overview of operation
// - Four prox thresholds in counts; prox flagged after six samples below average.
// - Halt timer starts on an event, restarts on event removal or repeat.
// - Channel average frozen during its event until clear or halt expiry.
// - Halt timer expiry clears every prox and touch output.
// - Counts outside target band at expiry start a new tuning run.
// - Fixed halt options hold baseline 20 or 40 s after last event.
// - Never-halt mode keeps average tracking; event clears as average drops.
// - Always mode: prox halts 40 s, touch halts while touch persists.
// - Four prox base choices, another four with alternative range.
// - Base values 200,50,100,250 default; 150,350,500,700 alternative.
// - Two charge transfer frequencies: default and 1MHz.
// - Link acts as target only, acknowledging address 0x44.
// - Ready low when able to talk, high while converting.
// - No address acknowledge while ready is high.
// - Noise detect enabled and noise seen blocks all outputs.
// - Power modes sample every 9, 32, 128 or 1000 ms.
// - Unprogrammed power mode samples at the 9 ms boost rate.
// - Possible event zooms to boost rate until zoom time passes quietly.
// - Zoom lasts 5 s and restarts on every undebounced detection.
// - Guard enabled: channel one touch blocks other touch output.
// - Outputs active high or low; low mode is open drain.
// - Out-of-band re-tune immediately or 10 s after prox clears.
// - Target option lowers targets to 500 prox and 250 touch.
// - Touch flagged after two samples at or below average minus threshold.
// - Halt code 00 20 s, 01 40 s, 10 never, 11 always.
// - Power code 00 boost, 01 normal, 10 slow one, 11 slow two.
package cec_pkg;
    localparam int unsigned CEC_CLK_HZ  = 40_000_000;
    localparam int unsigned CEC_MS_CYC  = CEC_CLK_HZ / 1000;
    localparam logic [15:0] CEC_T_BOOST_MS  = 16'd9;
    localparam logic [15:0] CEC_T_NORMAL_MS = 16'd32;
    localparam logic [15:0] CEC_T_SLOW1_MS  = 16'd128;
    localparam logic [15:0] CEC_T_SLOW2_MS  = 16'd1000;
    localparam logic [15:0] CEC_T_ZOOM_MS  = 16'd5000;
    localparam logic [15:0] CEC_T_HALT20_MS = 16'd20000;
    localparam logic [15:0] CEC_T_HALT40_MS = 16'd40000;
    localparam logic [15:0] CEC_T_RTDLY_MS = 16'd10000;
    localparam logic [2:0]  CEC_PROX_DBC   = 3'd6;
    localparam logic [2:0]  CEC_TOUCH_DBC  = 3'd2;
    localparam logic [12:0] CEC_BAND_WIDE  = 13'd160;
    localparam logic [12:0] CEC_BAND_NARROW = 13'd80;
    localparam logic [12:0] CEC_TGT_PROX_HI = 13'd1000;
    localparam logic [12:0] CEC_TGT_PROX_LO = 13'd500;
    localparam logic [12:0] CEC_TGT_TCH_HI = 13'd500;
    localparam logic [12:0] CEC_TGT_TCH_LO = 13'd250;
    localparam logic [12:0] CEC_PROX_THR_0 = 13'd4;
    localparam logic [12:0] CEC_PROX_THR_1 = 13'd8;
    localparam logic [12:0] CEC_PROX_THR_2 = 13'd16;
    localparam logic [12:0] CEC_PROX_THR_3 = 13'd32;
    localparam logic [9:0]  CEC_BASE_D0 = 10'd200;
    localparam logic [9:0]  CEC_BASE_D1 = 10'd50;
    localparam logic [9:0]  CEC_BASE_D2 = 10'd100;
    localparam logic [9:0]  CEC_BASE_D3 = 10'd250;
    localparam logic [9:0]  CEC_BASE_A0 = 10'd150;
    localparam logic [9:0]  CEC_BASE_A1 = 10'd350;
    localparam logic [9:0]  CEC_BASE_A2 = 10'd500;
    localparam logic [9:0]  CEC_BASE_A3 = 10'd700;
    localparam logic [6:0]  CEC_LINK_ADDR = 7'h44;
    localparam logic [7:0]  CEC_OFS_CFG  = 8'h00;
    localparam logic [7:0]  CEC_OFS_STAT = 8'h04;
    localparam logic [7:0]  CEC_OFS_AVG  = 8'h08;
    localparam logic [1:0]  CEC_HALT_20 = 2'b00;
    localparam logic [1:0]  CEC_HALT_40 = 2'b01;
    localparam logic [1:0]  CEC_HALT_NEVER = 2'b10;
    localparam logic [1:0]  CEC_HALT_ALWAYS = 2'b11;
    localparam logic [1:0]  CEC_PM_BOOST = 2'b00;
    localparam logic [1:0]  CEC_PM_NORMAL = 2'b01;
    localparam logic [1:0]  CEC_PM_SLOW1 = 2'b10;
    localparam logic [1:0]  CEC_PM_SLOW2 = 2'b11;
    localparam int unsigned CEC_CFG_W = 18;

    typedef logic [11:0] cec_cnt_t;

    typedef struct packed {
        logic       target_low;
        logic       retune_delay;
        logic       active_high;
        logic       guard_en;
        logic [1:0] power_rate_select;
        logic       rf_noise_detect;
        logic       transfer_frequency_select;
        logic       base_range_select;
        logic [2:0] touch_thr_sel;
        logic [1:0] prox_base_sel;
        logic [1:0] prox_threshold;
        logic [1:0] halt_time;
    } cec_cfg_t;

    localparam cec_cfg_t CEC_CFG_RST = 18'h00000;
endpackage : cec_pkg

// [verilog/cec_top.sv]
// Event detection, halt, zoom and sample scheduling for the sensor.
// Assumes counts come on I_COUNTS with I_SAMPLE_VALID from same-clock logic.
module cec_top #(
    parameter int unsigned P_MS_CYC = cec_pkg::CEC_MS_CYC
) (
    input  wire logic                    I_CLK,
    input  wire logic                    I_RST,
    input  wire logic [7:0]              I_ADDR,
    input  wire logic [31:0]             I_WDATA,
    input  wire logic                    I_WR,
    input  wire logic                    I_RD,
    output logic      [31:0]             O_RDATA,
    input  wire logic                    I_SAMPLE_VALID,
    input  wire cec_pkg::cec_cnt_t [2:0] I_COUNTS,
    input  wire logic                    I_RF_NOISE,
    input  wire logic                    I_LINK_ADDR_VALID,
    input  wire logic [6:0]              I_LINK_ADDR,
    output logic                         O_LINK_ACK,
    output logic                         O_RDY,
    output logic                         O_CHARGE_START,
    output logic                         O_RETUNE,
    output logic                         O_TFRQ_1MHZ,
    output logic      [9:0]              O_PROX_BASE,
    output logic      [12:0]             O_TGT_PROX,
    output logic      [12:0]             O_TGT_TOUCH,
    output logic      [2:0]              O_EVT_O,
    output logic      [2:0]              O_EVT_OE_N
);
    import cec_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------
    function automatic logic [15:0] avg_step(input logic [15:0] avg, input cec_cnt_t cs);
        logic signed [17:0] diff;
        diff = $signed({2'b00, cs, 4'h0}) - $signed({2'b00, avg});
        avg_step = avg + 16'(diff >>> 4);
    endfunction : avg_step

    function automatic logic band_ok(input cec_cnt_t cs, input logic [12:0] tgt, input logic [12:0] band);
        band_ok = ({1'b0, cs} + band >= tgt) && ({1'b0, cs} <= tgt + band);
    endfunction : band_ok

    function automatic logic [15:0] rate_ms(input logic [1:0] pm);
        unique case (pm)
            CEC_PM_BOOST:  rate_ms = CEC_T_BOOST_MS;
            CEC_PM_NORMAL: rate_ms = CEC_T_NORMAL_MS;
            CEC_PM_SLOW1:  rate_ms = CEC_T_SLOW1_MS;
            CEC_PM_SLOW2:  rate_ms = CEC_T_SLOW2_MS;
        endcase
    endfunction : rate_ms

    // ------------------------------------------------------------
    // Configuration and noise input
    // ------------------------------------------------------------
    cec_cfg_t    cfg_q;
    logic        prog_q;
    logic        noise_m_q;
    logic        noise_s_q;

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            cfg_q  <= CEC_CFG_RST;
            prog_q <= 1'b0;
        end
        else if (I_WR && I_ADDR == CEC_OFS_CFG)
        begin
            cfg_q  <= I_WDATA[CEC_CFG_W-1:0];
            prog_q <= 1'b1;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            noise_m_q <= 1'b0;
            noise_s_q <= 1'b0;
        end
        else
        begin
            noise_m_q <= I_RF_NOISE;
            noise_s_q <= noise_m_q;
        end
    end

    // ------------------------------------------------------------
    // Millisecond tick and sample scheduler
    // ------------------------------------------------------------
    logic [31:0] ms_cnt_q;
    logic        tick;
    logic [15:0] samp_cnt_q;
    logic [15:0] period;
    logic        conv_q;
    logic        start_q;
    logic        samp_v;
    logic [15:0] zoom_cnt_q;
    logic        zoom;

    assign tick = (ms_cnt_q == P_MS_CYC - 1);
    assign zoom = (zoom_cnt_q != 16'h0000);
    assign period = (zoom || !prog_q) ? CEC_T_BOOST_MS : rate_ms(cfg_q.power_rate_select);
    assign samp_v = I_SAMPLE_VALID && conv_q;

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            ms_cnt_q <= 32'h0000_0000;
        else
            ms_cnt_q <= tick ? 32'h0000_0000 : ms_cnt_q + 32'd1;
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            samp_cnt_q <= 16'h0000;
            start_q    <= 1'b0;
        end
        else
        begin
            start_q <= 1'b0;
            if (tick)
            begin
                // >= so a shorter period from zoom takes effect at once
                if (samp_cnt_q + 16'd1 >= period)
                begin
                    samp_cnt_q <= 16'h0000;
                    start_q    <= 1'b1;
                end
                else
                    samp_cnt_q <= samp_cnt_q + 16'd1;
            end
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            conv_q <= 1'b0;
        else if (start_q)
            conv_q <= 1'b1;
        else if (I_SAMPLE_VALID)
            conv_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // Detection
    // ------------------------------------------------------------
    logic [2:0][15:0] avg_q;
    logic             seeded_q;
    cec_cnt_t [2:0]   cs_q;
    logic [2:0][2:0]  dbc_q;
    logic [2:0]       evt_q;
    logic [2:0]       evt_prev_q;
    logic [2:0][12:0] thr;
    logic [2:0]       cond;
    logic [2:0]       frozen;
    logic             halt_en;
    logic             halt_exp;
    logic             exp_q;

    assign halt_en = (cfg_q.halt_time != CEC_HALT_NEVER);

    always_comb
    begin
        unique case (cfg_q.prox_threshold)
            2'd0: thr[0] = CEC_PROX_THR_0;
            2'd1: thr[0] = CEC_PROX_THR_1;
            2'd2: thr[0] = CEC_PROX_THR_2;
            2'd3: thr[0] = CEC_PROX_THR_3;
        endcase
        for (int i = 1; i < 3; i++)
            thr[i] = {1'b0, avg_q[i][15:4] >> (4'd2 + {1'b0, cfg_q.touch_thr_sel})};
        // touch at or below average minus threshold
        for (int i = 0; i < 3; i++)
            cond[i] = seeded_q && ({1'b0, avg_q[i][15:4]} >= {1'b0, I_COUNTS[i]} + thr[i]);
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            dbc_q <= '0;
            evt_q <= 3'b000;
        end
        else if (halt_exp)
        begin
            dbc_q <= '0;
            evt_q <= 3'b000;
        end
        else if (samp_v)
        begin
            for (int i = 0; i < 3; i++)
            begin
                if (!cond[i])
                begin
                    dbc_q[i] <= 3'd0;
                    evt_q[i] <= 1'b0;
                end
                else if (dbc_q[i] + 3'd1 >= ((i == 0) ? CEC_PROX_DBC : CEC_TOUCH_DBC))
                begin
                    dbc_q[i] <= (i == 0) ? CEC_PROX_DBC : CEC_TOUCH_DBC;
                    evt_q[i] <= 1'b1;
                end
                else
                    dbc_q[i] <= dbc_q[i] + 3'd1;
            end
        end
    end

    assign frozen = halt_en ? evt_q : 3'b000;

    // never mode keeps tracking; reseed after expiry drops the event
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            avg_q    <= '0;
            cs_q     <= '0;
            seeded_q <= 1'b0;
        end
        else if (halt_exp)
        begin
            for (int i = 0; i < 3; i++)
                avg_q[i] <= {cs_q[i], 4'h0};
        end
        else if (samp_v)
        begin
            seeded_q <= 1'b1;
            cs_q     <= I_COUNTS;
            for (int i = 0; i < 3; i++)
            begin
                if (!seeded_q)
                    avg_q[i] <= {I_COUNTS[i], 4'h0};
                else if (!frozen[i])
                    avg_q[i] <= avg_step(avg_q[i], I_COUNTS[i]);
            end
        end
    end

    // ------------------------------------------------------------
    // Halt timer
    // ------------------------------------------------------------
    logic        halt_run_q;
    logic [15:0] halt_cnt_q;
    logic [15:0] halt_lim;
    logic        halt_restart;
    logic        halt_hold;

    assign halt_lim = (cfg_q.halt_time == CEC_HALT_20) ? CEC_T_HALT20_MS : CEC_T_HALT40_MS;
    assign halt_restart = (evt_q != evt_prev_q) && !exp_q && halt_en;
    // touch holds the timer in always mode
    assign halt_hold = (cfg_q.halt_time == CEC_HALT_ALWAYS) && (|evt_q[2:1]);
    assign halt_exp = halt_run_q && tick && !halt_hold && (halt_cnt_q + 16'd1 >= halt_lim);

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            evt_prev_q <= 3'b000;
            exp_q      <= 1'b0;
        end
        else
        begin
            evt_prev_q <= evt_q;
            exp_q      <= halt_exp;
        end
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            halt_run_q <= 1'b0;
            halt_cnt_q <= 16'h0000;
        end
        else if (!halt_en)
        begin
            halt_run_q <= 1'b0;
            halt_cnt_q <= 16'h0000;
        end
        else if (halt_restart || halt_hold)
        begin
            halt_run_q <= 1'b1;
            halt_cnt_q <= 16'h0000;
        end
        else if (halt_exp)
        begin
            halt_run_q <= 1'b0;
            halt_cnt_q <= 16'h0000;
        end
        else if (halt_run_q && tick)
            halt_cnt_q <= halt_cnt_q + 16'd1;
    end

    // ------------------------------------------------------------
    // Zoom
    // ------------------------------------------------------------
    // reload on undebounced detection
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            zoom_cnt_q <= 16'h0000;
        else if (samp_v && (|cond))
            zoom_cnt_q <= CEC_T_ZOOM_MS;
        else if (tick && zoom)
            zoom_cnt_q <= zoom_cnt_q - 16'd1;
    end

    // ------------------------------------------------------------
    // Re-tune request
    // ------------------------------------------------------------
    logic [12:0] tgt_p;
    logic [12:0] tgt_t;
    logic [12:0] band;
    logic        in_band;
    logic        ret_start;
    logic        ret_pend_q;
    logic [15:0] ret_cnt_q;
    logic        ret_q;

    assign tgt_p = cfg_q.target_low ? CEC_TGT_PROX_LO : CEC_TGT_PROX_HI;
    assign tgt_t = cfg_q.target_low ? CEC_TGT_TCH_LO : CEC_TGT_TCH_HI;
    assign band = cfg_q.target_low ? CEC_BAND_NARROW : CEC_BAND_WIDE;
    assign in_band = band_ok(cs_q[0], tgt_p, band) && band_ok(cs_q[1], tgt_t, band)
                     && band_ok(cs_q[2], tgt_t, band);
    // out of band at expiry or prox clear
    assign ret_start = (halt_exp || (evt_prev_q[0] && !evt_q[0])) && !in_band;

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            ret_pend_q <= 1'b0;
            ret_cnt_q  <= 16'h0000;
            ret_q      <= 1'b0;
        end
        else
        begin
            ret_q <= 1'b0;
            if (ret_start)
            begin
                ret_pend_q <= 1'b1;
                ret_cnt_q  <= 16'h0000;
            end
            else if (ret_pend_q && (!cfg_q.retune_delay || (tick && ret_cnt_q + 16'd1 >= CEC_T_RTDLY_MS)))
            begin
                ret_pend_q <= 1'b0;
                ret_q      <= 1'b1;
            end
            else if (ret_pend_q && tick)
                ret_cnt_q <= ret_cnt_q + 16'd1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    logic [2:0] act;

    always_comb
    begin
        act = evt_q;
        if (cfg_q.guard_en && evt_q[1])
            act[2] = 1'b0;
        if (cfg_q.rf_noise_detect && noise_s_q)
            act = 3'b000;
    end

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_EVT_O    <= 3'b000;
            O_EVT_OE_N <= 3'b111;
        end
        else if (cfg_q.active_high)
        begin
            O_EVT_O    <= act;
            O_EVT_OE_N <= 3'b000;
        end
        else
        begin
            O_EVT_O    <= 3'b000;
            O_EVT_OE_N <= ~act;
        end
    end

    // tuning settings to the front end
    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
        begin
            O_PROX_BASE <= CEC_BASE_D0;
            O_TFRQ_1MHZ <= 1'b0;
            O_TGT_PROX  <= CEC_TGT_PROX_HI;
            O_TGT_TOUCH <= CEC_TGT_TCH_HI;
        end
        else
        begin
            unique case ({cfg_q.base_range_select, cfg_q.prox_base_sel})
                3'd0: O_PROX_BASE <= CEC_BASE_D0;
                3'd1: O_PROX_BASE <= CEC_BASE_D1;
                3'd2: O_PROX_BASE <= CEC_BASE_D2;
                3'd3: O_PROX_BASE <= CEC_BASE_D3;
                3'd4: O_PROX_BASE <= CEC_BASE_A0;
                3'd5: O_PROX_BASE <= CEC_BASE_A1;
                3'd6: O_PROX_BASE <= CEC_BASE_A2;
                3'd7: O_PROX_BASE <= CEC_BASE_A3;
            endcase
            O_TFRQ_1MHZ <= cfg_q.transfer_frequency_select;
            O_TGT_PROX  <= tgt_p;
            O_TGT_TOUCH <= tgt_t;
        end
    end

    // address match only while ready low
    assign O_LINK_ACK = I_LINK_ADDR_VALID && (I_LINK_ADDR == CEC_LINK_ADDR) && !conv_q;
    assign O_RDY = conv_q;
    assign O_CHARGE_START = start_q;
    assign O_RETUNE = ret_q;

    always_ff @(posedge I_CLK or posedge I_RST)
    begin
        if (I_RST)
            O_RDATA <= 32'h0000_0000;
        else if (!I_RD)
            O_RDATA <= 32'h0000_0000;
        else if (I_ADDR == CEC_OFS_CFG)
            O_RDATA <= {14'h0000, cfg_q};
        else if (I_ADDR == CEC_OFS_STAT)
            O_RDATA <= {23'h000000, conv_q, noise_s_q, prog_q, ret_pend_q, halt_run_q, zoom, evt_q};
        else if (I_ADDR == CEC_OFS_AVG)
            O_RDATA <= {16'h0000, avg_q[0]};
        else
            O_RDATA <= 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RST);

    prox_debounce_a: assert property ($rose(evt_q[0]) |-> $past(samp_v) && dbc_q[0] == 3'd6)
        else $error("prox flagged without six samples");
    halt_clear_a: assert property (halt_exp |=> evt_q == 3'b000)
        else $error("events survive halt expiry");
    avg_freeze_a: assert property (samp_v && halt_en && evt_q[0] && !halt_exp |=> $stable(avg_q[0]))
        else $error("average moved while halted");
    link_ack_a: assert property (O_LINK_ACK |-> !O_RDY && I_LINK_ADDR == 7'h44)
        else $error("ack while busy or wrong address");
    noise_block_a: assert property (cfg_q.rf_noise_detect && noise_s_q |=> O_EVT_O == 3'b000)
        else $error("output active under noise");
    guard_block_a: assert property (cfg_q.guard_en && evt_q[1] && cfg_q.active_high
                                    && $stable(cfg_q) |=> !O_EVT_O[2])
        else $error("guard did not block");
    zoom_rate_a: assert property (samp_v && (|cond) |=> period == 16'd9)
        else $error("no zoom to boost");
    open_drain_a: assert property (!$past(cfg_q.active_high) |-> O_EVT_O == 3'b000)
        else $error("open drain driven high");
    unprog_boost_a: assert property (!prog_q |-> period == 16'd9)
        else $error("unprogrammed not at boost");
    retune_exp_a: assert property (halt_exp && !in_band |=> ret_pend_q)
        else $error("no retune after expiry");

    prox_seen_c: cover property ($rose(evt_q[0]));
    halt_exp_c: cover property (halt_exp);
    retune_c: cover property (ret_q);
endmodule : cec_top

// [verif/cec_fe_model.sv]
// Front end model: answers each charge start with one sample.
// Assumes the block's clock; the bench sets counts and delay.
module cec_fe_model (
    input  wire logic                    i_clk,
    input  wire logic                    i_chg,
    input  wire logic [4:0]              i_dly,
    input  wire cec_pkg::cec_cnt_t [2:0] i_cnt,
    output logic                         o_vld,
    output cec_pkg::cec_cnt_t [2:0]      o_cnt
);
    timeunit 1ns;
    timeprecision 1ps;
    import cec_pkg::*;
    // Scrambled off-sample so stale counts are never taken
    assign o_cnt = o_vld ? i_cnt : ~i_cnt;
    initial
    begin
        o_vld = 1'b0;
        forever
        begin
            @(posedge i_clk);
            if (i_chg === 1'b1)
            begin
                repeat (i_dly + 1) @(posedge i_clk);
                o_vld <= 1'b1;
                @(posedge i_clk);
                o_vld <= 1'b0;
            end
        end
    end
endmodule : cec_fe_model

// [verif/tb.sv]
// Testbench for the event control block, with front end model.
// Assumes ms tick shortened to P cycles.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cec_pkg::*;
    localparam int unsigned P = 2;
    logic clk, rst, wr, rd, noise, lav, vld, ack, rdy, chg, rt, tf;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, d;
    logic [6:0] la;
    logic [4:0] dly;
    logic [9:0] base;
    logic [12:0] tp, tt;
    logic [2:0] eo, eoe_n, pin;
    cec_cnt_t [2:0] cnt, cts;
    int fails, cmp_count, rtc, n;
    logic [15:0] per [4] = '{16'h0009, 16'h0020, 16'h0080, 16'h03e8};
    logic [9:0] bv [8] = '{10'h0c8, 10'h096, 10'h032, 10'h15e, 10'h064, 10'h1f4, 10'h0fa, 10'h2bc};
    // Pull-up on each event wire while released
    assign pin = eo | eoe_n;
    cec_top #(.P_MS_CYC(P)) u_dut (.I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_SAMPLE_VALID(vld), .I_COUNTS(cts),
        .I_RF_NOISE(noise), .I_LINK_ADDR_VALID(lav), .I_LINK_ADDR(la), .O_LINK_ACK(ack),
        .O_RDY(rdy), .O_CHARGE_START(chg), .O_RETUNE(rt), .O_TFRQ_1MHZ(tf), .O_PROX_BASE(base),
        .O_TGT_PROX(tp), .O_TGT_TOUCH(tt), .O_EVT_O(eo), .O_EVT_OE_N(eoe_n));
    cec_fe_model u_fe (.i_clk(clk), .i_chg(chg), .i_dly(dly), .i_cnt(cnt), .o_vld(vld), .o_cnt(cts));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    always @(posedge clk) if (rt === 1'b1) rtc++;
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("wrong value %s expected %0h seen %0h", s, e, g);
            fails++;
        end
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick
    // Counts cycles until the chosen strobe is seen
    task automatic wsig(input bit v);
        n = 0;
        do
        begin
            tick(1);
            n++;
        end while ((v ? vld : chg) !== 1'b1 && n < 5000);
        if (n >= 5000)
        begin
            fails++;
            end_sim();
        end
    endtask : wsig
    task automatic wreg(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        tick(2);
    endtask : wreg
    task automatic rreg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rreg
    //---------------------------------------------
    // Scenarios
    //---------------------------------------------
    task automatic t_rate(input logic [15:0] ms);
        repeat (3) wsig(0);
        chk("period", ms * P, n);
    endtask : t_rate
    task automatic t_base;
        logic [31:0] c;
        for (int i = 0; i < 8; i++)
        begin
            c = {14'h0, i[2], 6'h0, i[0], i[2], 3'h0, i[1:0], 4'h0};
            wreg(8'h00, c);
            chk("base", bv[{i[1:0], i[2]}], base);
            chk("tgt_p", i[2] ? 13'h1f4 : 13'h3e8, tp);
            chk("tgt_t", i[2] ? 13'h0fa : 13'h1f4, tt);
            chk("tfrq", i[0], tf);
        end
        wreg(8'h0c, 32'hffff_ffff);
        rreg(8'h0c);
        chk("unmapped", 32'h0, d);
        rreg(8'h00);
        chk("cfg", 32'h0002_0630, d);
    endtask : t_base
    task automatic t_link;
        wsig(0);
        @(posedge clk);
        la <= 7'h44;
        lav <= 1'b1;
        #1 chk("rdy", 1'b1, rdy);
        chk("ack_busy", 1'b0, ack);
        wsig(1);
        tick(1);
        chk("rdy_idle", 1'b0, rdy);
        chk("ack", 1'b1, ack);
        @(posedge clk);
        la <= 7'h45;
        #1 chk("ack_other", 1'b0, ack);
        @(posedge clk);
        lav <= 1'b0;
    endtask : t_link
    task automatic t_prox;
        wreg(8'h00, 32'h0000_b000);
        @(posedge clk);
        cnt[0] <= 12'h320;
        dly <= 5'h0a;
        for (int k = 1; k < 7; k++)
        begin
            wsig(1);
            tick(3);
            if (k == 5) chk("prox_early", 1'b0, pin[0]);
            if (k == 1)
            begin
                rreg(8'h04);
                chk("zoom", 1'b1, d[3]);
            end
        end
        chk("prox", 1'b1, pin[0]);
        wreg(8'h00, 32'h0000_b800);
        @(posedge clk);
        noise <= 1'b1;
        tick(6);
        chk("blocked", 1'b0, pin[0]);
        @(posedge clk);
        noise <= 1'b0;
        wreg(8'h00, 32'h0000_3000);
        tick(6);
        chk("low_oe", 3'h6, eoe_n);
        chk("low_pin", 3'h6, pin);
        rtc = 0;
        n = 0;
        while (eoe_n[0] === 1'b0 && n < 21000 * P)
        begin
            tick(1);
            n++;
        end
        chk("halt", 1'b1, n > 19000 * P && n <= 20000 * P);
        tick(4);
        chk("cleared", 3'h7, eoe_n);
        chk("retune", 1'b1, rtc > 0);
    endtask : t_prox
    // Never-halt, guard on, active high: touch on both touch channels
    task automatic t_touch;
        wreg(8'h00, 32'h0000_c002);
        @(posedge clk);
        cnt[2:1] <= {12'h12c, 12'h12c};
        for (int k = 1; k < 17; k++)
        begin
            wsig(1);
            tick(3);
            if (k == 2) chk("guard", 3'h2, pin);
            if (k == 8) chk("touch_held", 3'h2, pin);
        end
        chk("touch_clear", 3'h0, pin);
    endtask : t_touch
    task automatic t_reset;
        rst = 1'b1;
        {wr, rd, noise, lav} = 4'h0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        la = 7'h00;
        dly = 5'h00;
        rtc = 0;
        cnt = {12'h1f4, 12'h1f4, 12'h3e8};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        tick(1);
        chk("rst_base", 10'h0c8, base);
        chk("rst_tgt", 13'h3e8, tp);
        chk("rst_oe", 3'h7, eoe_n);
    endtask : t_reset
    initial
    begin
        t_reset();
        t_rate(16'h0009);
        t_base();
        for (int m = 0; m < 4; m++)
        begin
            wreg(8'h00, {18'h0, 2'(m), 12'h0});
            t_rate(per[m]);
        end
        t_link();
        t_prox();
        t_touch();
        end_sim();
    end
endmodule : tb
